//--- air_pkg.sv
// Constants, carriers and types shared by the accelerometer bus readout block.
package air_pkg;

  // Own bus address, seven bits.
  localparam logic [6:0]  AIR_DEV_ADDR      = 7'h55;

  // Register pointer values.
  localparam logic [7:0]  AIR_REG_STATUS    = 8'h00;
  localparam logic [7:0]  AIR_REG_X_HI      = 8'h01;
  localparam logic [7:0]  AIR_REG_X_LO      = 8'h02;
  localparam logic [7:0]  AIR_REG_Y_HI      = 8'h03;
  localparam logic [7:0]  AIR_REG_Y_LO      = 8'h04;
  localparam logic [7:0]  AIR_REG_Z_HI      = 8'h05;
  localparam logic [7:0]  AIR_REG_Z_LO      = 8'h06;
  localparam logic [7:0]  AIR_REG_LAST      = 8'h06;
  localparam logic [7:0]  AIR_PTR_RST       = 8'h00;

  // Status layout and reset values.
  localparam logic [3:0]  AIR_STATUS_PAD    = 4'h0;
  localparam logic [2:0]  AIR_READY_RST     = 3'h0;
  localparam logic [2:0]  AIR_READY_ALL     = 3'h7;
  localparam logic [7:0]  AIR_DATA_RST      = 8'h00;

  // Sample layout: high register holds the top eight of fourteen bits.
  localparam int          AIR_SMP_W         = 14;
  localparam int          AIR_HI_LSB        = 6;
  localparam int          AIR_LO_W          = 6;
  localparam logic [1:0]  AIR_LO_PAD        = 2'h0;
  localparam logic [13:0] AIR_SAMPLE_RST    = 14'h0000;
  localparam logic [17:0] AIR_LO_HOLD_RST   = 18'h00000;

  // Bit count of one byte on the bus.
  localparam logic [3:0]  AIR_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  AIR_BIT_RST       = 4'h0;

  // One sample of all three axes.
  typedef struct packed {
    logic [13:0] z;
    logic [13:0] y;
    logic [13:0] x;
  } air_sample_t;

  // Fetch request crossing from the link side to the register side.
  typedef struct packed {
    logic       tgl;
    logic [7:0] ptr;
  } air_req_t;

  // Fetch answer crossing back to the link side.
  typedef struct packed {
    logic       tgl;
    logic [7:0] data;
  } air_rsp_t;

  // Bus engine states.
  typedef enum logic [3:0] {
    L_IDLE,
    L_ADDR,
    L_ADDR_ACK,
    L_PTR,
    L_PTR_ACK,
    L_WR,
    L_WR_ACK,
    L_TX,
    L_TX_ACK
  } air_state_t;

endpackage : air_pkg

//--- air_i2c_regs.sv
// Bus slave and read-only sample register map of a three-axis accelerometer.
//
// What this block and its host must do
// RQ1 - Bus answers only while trigger pin high.
// RQ2 - Host discards bytes read with trigger low.
// RQ3 - Lines idle high; works up to 400 kHz.
// RQ4 - Detect start: data falls, clock high.
// RQ5 - Address byte: seven address bits, direction last.
// RQ6 - Ninth clock: transmitter releases, receiver pulls low.
// RQ7 - Stop returns the engine to idle.
// RQ8 - Repeated start accepted without stop.
// RQ9 - Own address is 0x55.
// RQ10 - Single read: pointer write, restart, one byte.
// RQ11 - Data shifted out most significant first.
// RQ12 - Burst read advances pointer per acknowledged byte.
// RQ13 - Pointer wraps from 0x06 to 0x00.
// RQ14 - Stop clears the stored pointer.
// RQ15 - Registers keep contents; trigger low clears them.
// RQ16 - Status: zeros, all-ready, Z, Y, X flags.
// RQ17 - All-ready clears after all high bytes read.
// RQ18 - Axis flag clears when its high byte read.
// RQ19 - Fourteen-bit sample split high and low.
// RQ20 - Low byte valid only after its high byte.
// RQ21 - High read captures matching low byte.
// RQ22 - Host reads data after all-ready flag.
// RQ23 - Never stretches the bus clock.
// RQ24 - New sample stored when conversion completes.
// RQ25 - Written data bytes acknowledged and ignored.
// RQ26 - Unmapped pointer reads zero, no side effect.
`timescale 1ns/1ps
`default_nettype none

module air_i2c_regs
(
  // System clock and reset.
  input  wire logic                 CLK_IN,
  input  wire logic                 RESETN_IN,
  // Link clock that oversamples the bus pins.
  input  wire logic                 LINK_CLK_IN,
  // Trigger pin and conversion results.
  input  wire logic                 EN_IN,
  input  wire logic                 SAMPLE_VALID_IN,
  input  wire air_pkg::air_sample_t SAMPLE_IN,
  // Serial bus pins; the clock line is input only.
  input  wire logic                 SCL_IN,
  input  wire logic                 SDA_IN,
  output logic                      SDA_OUT,
  output logic                      SDA_OE_OUT
);
  import air_pkg::*;

  // Register side (system clock).
  logic        en_meta_r;
  logic        en_sync_r;
  logic        smp_ok;
  air_sample_t smp_r;
  logic [2:0]  ready_r;
  logic        all_r;
  logic [2:0]  hi_seen_r;
  logic [2:0]  hi_rd;
  logic [17:0] lo_hold_r;
  logic [2:0]  req_sy_r;
  logic        req_evt;
  air_rsp_t    rsp_r;

  // Link side (link clock).
  logic [1:0]  lrst_r;
  logic        lrst_n;
  logic [2:0]  scl_r;
  logic [2:0]  sda_r;
  logic [1:0]  en_l_r;
  logic [2:0]  rsp_l_r;
  logic        scl_s;
  logic        sda_s;
  logic        en_ls;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        rsp_evt;
  air_state_t  st_r;
  air_state_t  st_nxt;
  logic [3:0]  bit_r;
  logic [3:0]  bit_nxt;
  logic [7:0]  rx_r;
  logic [7:0]  rx_nxt;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;
  logic        fetch;
  logic [7:0]  fetch_ptr;
  air_req_t    req_r;
  logic [7:0]  tx_r;
  logic        loaded_r;
  logic        dev_ack;
  logic        sda_oe_r;
  logic        sda_oe_nxt;
  logic        sda_out_r;

  // Register read decode; out-of-map pointers return zero.
  function automatic logic [7:0] air_reg_read(input logic [7:0]  ptr,
                                              input air_sample_t s,
                                              input logic [2:0]  rdy,
                                              input logic        all,
                                              input logic [17:0] lo);
    logic [7:0] d;
    d = AIR_DATA_RST;
    case (ptr)
      AIR_REG_STATUS: d = {AIR_STATUS_PAD, all, rdy};                        // [RQ16]
      AIR_REG_X_HI:   d = s.x[AIR_SMP_W-1:AIR_HI_LSB];                       // [RQ19]
      AIR_REG_X_LO:   d = {lo[AIR_LO_W-1:0], AIR_LO_PAD};                    // [RQ19] [RQ20]
      AIR_REG_Y_HI:   d = s.y[AIR_SMP_W-1:AIR_HI_LSB];
      AIR_REG_Y_LO:   d = {lo[2*AIR_LO_W-1:AIR_LO_W], AIR_LO_PAD};
      AIR_REG_Z_HI:   d = s.z[AIR_SMP_W-1:AIR_HI_LSB];
      AIR_REG_Z_LO:   d = {lo[3*AIR_LO_W-1:2*AIR_LO_W], AIR_LO_PAD};
      default:        d = AIR_DATA_RST;                                      // [RQ26]
    endcase
    return d;
  endfunction : air_reg_read

  // Auto-increment step of the register pointer.
  function automatic logic [7:0] air_next_ptr(input logic [7:0] ptr);
    return (ptr == AIR_REG_LAST) ? AIR_PTR_RST : 8'(ptr + 8'h01);              // [RQ13]
  endfunction : air_next_ptr

  // Trigger pin synchroniser on the system clock.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
    end
    else
    begin
      en_meta_r <= EN_IN;
      en_sync_r <= en_meta_r;
    end
  end

  // Conversion results are only taken while the trigger pin is high.
  assign smp_ok = SAMPLE_VALID_IN & en_sync_r;                               // [RQ24]

  // Sample store; held while the pin stays high, cleared when it drops.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      smp_r <= {AIR_SAMPLE_RST, AIR_SAMPLE_RST, AIR_SAMPLE_RST};
    else if (!en_sync_r)
      smp_r <= {AIR_SAMPLE_RST, AIR_SAMPLE_RST, AIR_SAMPLE_RST};            // [RQ15]
    else if (smp_ok)
      smp_r <= SAMPLE_IN;                                                    // [RQ24]
  end

  // Fetch request toggle crossing; the pointer is stable until the next toggle.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      req_sy_r <= 3'h0;
    else
      req_sy_r <= {req_sy_r[1:0], req_r.tgl};
  end

  assign req_evt = req_sy_r[1] ^ req_sy_r[2];

  // High-byte reads that carry side effects this cycle.
  always_comb
  begin
    hi_rd[0] = req_evt && (req_r.ptr == AIR_REG_X_HI);
    hi_rd[1] = req_evt && (req_r.ptr == AIR_REG_Y_HI);
    hi_rd[2] = req_evt && (req_r.ptr == AIR_REG_Z_HI);
  end

  // Axis flags: a new sample outranks a clear in the same cycle.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      ready_r <= AIR_READY_RST;
    else if (!en_sync_r)
      ready_r <= AIR_READY_RST;                                              // [RQ15]
    else
      ready_r <= (ready_r & ~hi_rd) | {3{smp_ok}};                           // [RQ16] [RQ18]
  end

  // All-axes flag tracks which high bytes were read since it was set.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      all_r     <= 1'b0;
      hi_seen_r <= AIR_READY_RST;
    end
    else if (!en_sync_r)
    begin
      all_r     <= 1'b0;
      hi_seen_r <= AIR_READY_RST;
    end
    else if (smp_ok)
    begin
      all_r     <= 1'b1;                                                     // [RQ16]
      hi_seen_r <= AIR_READY_RST;
    end
    else
    begin
      hi_seen_r <= hi_seen_r | hi_rd;
      if ((hi_seen_r | hi_rd) == AIR_READY_ALL)
        all_r <= 1'b0;                                                       // [RQ17]
    end
  end

  // Low bytes are frozen at the high-byte read so a pair never tears.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      lo_hold_r <= AIR_LO_HOLD_RST;
    else if (!en_sync_r)
      lo_hold_r <= AIR_LO_HOLD_RST;
    else
    begin
      if (hi_rd[0])
        lo_hold_r[AIR_LO_W-1:0] <= smp_r.x[AIR_LO_W-1:0];                    // [RQ21]
      if (hi_rd[1])
        lo_hold_r[2*AIR_LO_W-1:AIR_LO_W] <= smp_r.y[AIR_LO_W-1:0];
      if (hi_rd[2])
        lo_hold_r[3*AIR_LO_W-1:2*AIR_LO_W] <= smp_r.z[AIR_LO_W-1:0];
    end
  end

  // Answer to a fetch: data and toggle change in the same cycle, then hold.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      rsp_r <= {1'b0, AIR_DATA_RST};
    else if (req_evt)
      rsp_r <= {~rsp_r.tgl, air_reg_read(req_r.ptr, smp_r, ready_r, all_r, lo_hold_r)};
  end

  // Link reset: asserted at once, released on the link clock.
  always_ff @(posedge LINK_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      lrst_r <= 2'h0;
    else
      lrst_r <= {lrst_r[0], 1'b1};
  end

  assign lrst_n = lrst_r[1];

  // Pin and answer synchronisers; the third stage only feeds edge detection.
  always_ff @(posedge LINK_CLK_IN or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      scl_r   <= 3'h7;
      sda_r   <= 3'h7;
      en_l_r  <= 2'h0;
      rsp_l_r <= 3'h0;
    end
    else
    begin
      scl_r   <= {scl_r[1:0], SCL_IN};                                       // [RQ3]
      sda_r   <= {sda_r[1:0], SDA_IN};
      en_l_r  <= {en_l_r[0], EN_IN};
      rsp_l_r <= {rsp_l_r[1:0], rsp_r.tgl};
    end
  end

  // Bus events seen on the synchronised lines.
  assign scl_s     = scl_r[1];
  assign sda_s     = sda_r[1];
  assign en_ls     = en_l_r[1];
  assign scl_rise  = scl_r[1] & ~scl_r[2];
  assign scl_fall  = ~scl_r[1] & scl_r[2];
  assign start_det = scl_s & scl_r[2] & sda_r[2] & ~sda_s;                   // [RQ4]
  assign stop_det  = scl_s & scl_r[2] & ~sda_r[2] & sda_s;                   // [RQ7]
  assign rsp_evt   = rsp_l_r[1] ^ rsp_l_r[2];
  assign dev_ack   = (st_r == L_ADDR_ACK) || (st_r == L_PTR_ACK) || (st_r == L_WR_ACK);

  // Bus engine next state; the clock line is only ever sampled.
  always_comb
  begin
    st_nxt    = st_r;
    bit_nxt   = bit_r;
    rx_nxt    = rx_r;
    ptr_nxt   = ptr_r;
    fetch     = 1'b0;
    fetch_ptr = ptr_r;
    if (!en_ls)
      st_nxt = L_IDLE;                                                       // [RQ1] [RQ23]
    else if (stop_det)
    begin
      st_nxt  = L_IDLE;                                                      // [RQ7]
      ptr_nxt = AIR_PTR_RST;                                                 // [RQ14]
    end
    else if (start_det)
    begin
      st_nxt  = L_ADDR;                                                      // [RQ4] [RQ8]
      bit_nxt = AIR_BIT_RST;
    end
    else
    begin
      unique case (st_r)
        L_IDLE:
          st_nxt = L_IDLE;
        L_ADDR, L_PTR, L_WR:
          if (scl_rise)
          begin
            rx_nxt  = {rx_r[6:0], sda_s};
            bit_nxt = 4'(bit_r + 4'h1);
          end
          else if (scl_fall && (bit_r == AIR_BITS_PER_BYTE))
          begin
            bit_nxt = AIR_BIT_RST;
            if (st_r == L_ADDR)
            begin
              if (rx_r[7:1] == AIR_DEV_ADDR)                                 // [RQ5] [RQ9]
              begin
                st_nxt = L_ADDR_ACK;
                fetch  = rx_r[0];                                            // [RQ10]
              end
              else
                st_nxt = L_IDLE;
            end
            else if (st_r == L_PTR)
            begin
              st_nxt  = L_PTR_ACK;
              ptr_nxt = rx_r;                                                // [RQ10]
            end
            else
              st_nxt = L_WR_ACK;                                             // [RQ25]
          end
        L_ADDR_ACK, L_PTR_ACK, L_WR_ACK:
          if (scl_fall)
          begin
            if (st_r == L_ADDR_ACK)
              st_nxt = rx_r[0] ? L_TX : L_PTR;
            else
              st_nxt = L_WR;                                                 // [RQ25]
          end
        L_TX:
          if (scl_rise)
            bit_nxt = 4'(bit_r + 4'h1);
          else if (scl_fall && (bit_r == AIR_BITS_PER_BYTE))
          begin
            st_nxt  = L_TX_ACK;
            bit_nxt = AIR_BIT_RST;
          end
        L_TX_ACK:
          if (scl_rise)
          begin
            if (sda_s)
              st_nxt = L_IDLE;                                               // [RQ10] [RQ12]
            else
            begin
              ptr_nxt   = air_next_ptr(ptr_r);                               // [RQ12] [RQ13]
              fetch     = 1'b1;
              fetch_ptr = air_next_ptr(ptr_r);
            end
          end
          else if (scl_fall)
            st_nxt = L_TX;
        default:
          st_nxt = L_IDLE;
      endcase
    end
  end

  // Bus engine state registers.
  always_ff @(posedge LINK_CLK_IN or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      st_r  <= L_IDLE;
      bit_r <= AIR_BIT_RST;
      rx_r  <= AIR_DATA_RST;
      ptr_r <= AIR_PTR_RST;
    end
    else
    begin
      st_r  <= st_nxt;
      bit_r <= bit_nxt;
      rx_r  <= rx_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  // Fetch request; the pointer changes together with the toggle.
  always_ff @(posedge LINK_CLK_IN or negedge lrst_n)
  begin
    if (!lrst_n)
      req_r <= {1'b0, AIR_PTR_RST};
    else if (fetch)
      req_r <= {~req_r.tgl, fetch_ptr};
  end

  // Transmit shifter; a late answer holds the line released until it lands.
  always_ff @(posedge LINK_CLK_IN or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      tx_r     <= AIR_DATA_RST;
      loaded_r <= 1'b0;
    end
    else if (rsp_evt)
    begin
      tx_r     <= rsp_r.data;
      loaded_r <= 1'b1;
    end
    else
    begin
      if (fetch)
        loaded_r <= 1'b0;
      if ((st_r == L_TX) && scl_fall && (bit_r != AIR_BITS_PER_BYTE))
        tx_r <= {tx_r[6:0], 1'b0};                                           // [RQ11]
    end
  end

  // Line drive: pull low for our acknowledge and for zero data bits.
  always_comb
  begin
    sda_oe_nxt = 1'b0;
    if (dev_ack)
      sda_oe_nxt = 1'b1;                                                     // [RQ6]
    else if (st_r == L_TX)
      sda_oe_nxt = loaded_r & ~tx_r[7];                                      // [RQ11]
  end

  // Registered pin drive; the data pin only ever drives low.
  always_ff @(posedge LINK_CLK_IN or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      sda_oe_r  <= 1'b0;
      sda_out_r <= 1'b0;
    end
    else
    begin
      sda_oe_r  <= sda_oe_nxt;
      sda_out_r <= 1'b0;
    end
  end

  assign SDA_OUT    = sda_out_r;
  assign SDA_OE_OUT = sda_oe_r;

  // Checks on the register side.
  // Any read order counts: the last of the three high bytes, whichever it is, clears the flag.
  sequence s_all_read;
    (hi_rd != 3'h0) && ((hi_seen_r | hi_rd) == AIR_READY_ALL) && !smp_ok && en_sync_r;
  endsequence

  flags_set_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [RQ16]
    smp_ok |=> (ready_r == AIR_READY_ALL) && all_r)
    else $error("sample did not set all ready flags");
  x_clear_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [RQ18]
    hi_rd[0] && !smp_ok && en_sync_r |=> !ready_r[0])
    else $error("x flag not cleared by high byte read");
  all_clear_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [RQ17]
    s_all_read |=> !all_r)
    else $error("all ready flag survived reading all high bytes");
  lo_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [RQ21]
    hi_rd[1] && en_sync_r |=> lo_hold_r[11:6] == $past(smp_r.y[5:0]))
    else $error("low byte not captured at high byte read");
  en_clear_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [RQ15]
    !en_sync_r |=> (ready_r == AIR_READY_RST) && !all_r && (smp_r.x == AIR_SAMPLE_RST))
    else $error("registers not cleared with trigger low");
  status_pad_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [RQ16]
    req_evt && (req_r.ptr == AIR_REG_STATUS) |=> rsp_r.data[7:4] == AIR_STATUS_PAD)
    else $error("status upper bits not zero");

  // Checks on the link side.
  sequence s_ack_hold;
    dev_ack ##1 dev_ack;
  endsequence

  sequence s_stop;
    en_ls && stop_det;
  endsequence

  stop_idle_a: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n) // [RQ7]
    s_stop |=> (st_r == L_IDLE) && (ptr_r == AIR_PTR_RST))
    else $error("stop did not return to idle with pointer cleared");
  en_off_a: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n) // [RQ1]
    !en_ls [*3] |-> !sda_oe_r)
    else $error("data line driven with trigger low");
  ack_drive_a: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n) // [RQ6]
    s_ack_hold |-> sda_oe_r)
    else $error("acknowledge not driven low");
  tx_release_a: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n) // [RQ6]
    (st_r == L_TX_ACK) ##1 (st_r == L_TX_ACK) |-> !sda_oe_r)
    else $error("line not released for host acknowledge");
  addr_match_a: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n) // [RQ9]
    $rose(st_r == L_ADDR_ACK) |-> rx_r[7:1] == AIR_DEV_ADDR)
    else $error("acknowledged a foreign address");
  wrap_a: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n) // [RQ13]
    en_ls && !stop_det && !start_det && (st_r == L_TX_ACK) && scl_rise && !sda_s
      && (ptr_r == AIR_REG_LAST) |=> ptr_r == AIR_PTR_RST)
    else $error("pointer did not wrap after last register");

endmodule : air_i2c_regs

`default_nettype wire

//--- air_host_model.sv
// Host controller model driving the two-wire bus as master.
`timescale 1ns/1ps
`default_nettype none

module air_host_model
(
  // Bus lines; a pull of one holds the data line low.
  output logic      scl_out,
  output logic      sda_pull_out,
  input  wire logic sda_in
);
  // Data lead (a fifth of the low time), low and high times of a clock of about 533 kHz.
  localparam int TQ = 250;
  localparam int TL = 1250;
  localparam int TH = 625;

  // The clock starts driven high and the data line released, so its pull-up holds it high.
  initial
  begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
  end

  // Data falls while the clock is high, also as a repeated start.
  task automatic start();
    #TQ sda_pull_out = 1'b0;
    #(TL - TQ) scl_out = 1'b1;
    #TH sda_pull_out = 1'b1;
    #TH scl_out = 1'b0;
  endtask : start

  // Data rises while the clock is high to end the transfer.
  task automatic stop();
    #TQ sda_pull_out = 1'b1;
    #(TL - TQ) scl_out = 1'b1;
    #TH sda_pull_out = 1'b0;
    #TL;
  endtask : stop

  // Data moves a fifth into the low phase, never beside a clock edge.
  task automatic wbit(input logic b);
    #TQ sda_pull_out = ~b;
    #(TL - TQ) scl_out = 1'b1;
    #TH scl_out = 1'b0;
  endtask : wbit

  // The line is released and sampled in mid high phase.
  task automatic rbit(output logic b);
    #TQ sda_pull_out = 1'b0;
    #(TL - TQ) scl_out = 1'b1;
    #(TH / 2) b = sda_in;
    #(TH - TH / 2) scl_out = 1'b0;
  endtask : rbit

  // Byte out most significant first, then the answer bit.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      wbit(d[i]);
    rbit(ack);
  endtask : wbyte

  // Byte in most significant first.
  task automatic rbyte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      rbit(d[i]);
  endtask : rbyte
endmodule : air_host_model
`default_nettype wire

//--- air_i2c_regs_test.sv
// Self-checking bench for the accelerometer bus readout block.
`timescale 1ns/1ps
`default_nettype none

module air_i2c_regs_test;
  import air_pkg::*;

  // Table row: register pointer and the byte it returns.
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] exp;
  } air_row_t;

  localparam air_sample_t S1 = {14'h0F0F, 14'h2345, 14'h1ABC};
  localparam air_sample_t S2 = {14'h2AAA, 14'h0155, 14'h3001};

  logic        clk, lclk, rstn, en, sv, scl, hpull, oe, sdo, a;
  logic [7:0]  d;
  air_sample_t smp_in;
  air_row_t    rows [4];
  logic [7:0]  bexp [7];
  int          failures, n_checks, cyc;
  // Open-drain data line with a pull-up.
  wire logic   sda = (oe ? sdo : 1'b1) & ~hpull;

  air_i2c_regs uut
  (
    .CLK_IN          (clk),
    .RESETN_IN       (rstn),
    .LINK_CLK_IN     (lclk),
    .EN_IN           (en),
    .SAMPLE_VALID_IN (sv),
    .SAMPLE_IN       (smp_in),
    .SCL_IN          (scl),
    .SDA_IN          (sda),
    .SDA_OUT         (sdo),
    .SDA_OE_OUT      (oe)
  );

  air_host_model host (.scl_out(scl), .sda_pull_out(hpull), .sda_in(sda));

  function automatic logic [7:0] hi(input logic [13:0] v);
    return v[13:6];
  endfunction : hi

  function automatic logic [7:0] lo(input logic [13:0] v);
    return {v[5:0], 2'h0};
  endfunction : lo

  // System clock, then a link clock of unrelated phase.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #17;
    forever #62.5 lclk = ~lclk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // The host runs on fixed delays and never waits on the bus engine; the cap only bounds the run.
  // A clean run needs about 94,000 cycles, so the cap leaves a small margin.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 98000)
    begin
      failures++;
      results();
    end
  end

  // Pointer write, then a repeated start into a read.
  task automatic sel(input logic [7:0] p);
    host.start();
    host.wbyte(8'hAA, a);
    chk("ack", 8'h00, {7'h0, a});
    host.wbyte(p, a);
    chk("ack", 8'h00, {7'h0, a});
    host.start();
    host.wbyte(8'hAB, a);
    chk("ack", 8'h00, {7'h0, a});
  endtask : sel

  // One byte, refused with no-acknowledge, then stop.
  task automatic rd1(input logic [7:0] p, output logic [7:0] v);
    sel(p);
    host.rbyte(v);
    host.wbit(1'b1);
    host.stop();
  endtask : rd1

  task automatic smp(input air_sample_t s);
    @(posedge clk);
    sv     <= 1'b1;
    smp_in <= s;
    @(posedge clk);
    sv <= 1'b0;
  endtask : smp

  initial
  begin
    {rstn, sv, failures, n_checks} = '0;
    en = 1'b1;
    smp_in = '0;
    // Status is read before and after the y high byte, then an unmapped pointer reads zero.
    rows = '{'{8'h00, 8'h0F}, '{8'h03, hi(S1.y)}, '{8'h00, 8'h0D}, '{8'h07, 8'h00}};
    bexp = '{hi(S2.y), lo(S2.y), hi(S2.z), lo(S2.z), 8'h09, hi(S2.x), lo(S2.x)};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge lclk);
    smp(S1);
    for (int i = 0; i < 4; i++)
    begin
      rd1(rows[i].ptr, d);
      chk("row", rows[i].exp, d);
    end
    $display("test rows done");
    // Burst across the wrap, with a new sample after the high byte.
    // The x high byte comes last after the wrap, so it clears the all-ready flag.
    sel(AIR_REG_X_HI);
    host.rbyte(d);
    chk("x hi", hi(S1.x), d);
    smp(S2);
    host.wbit(1'b0);
    host.rbyte(d);
    chk("x lo", lo(S1.x), d);
    for (int i = 0; i < 7; i++)
    begin
      host.wbit(1'b0);
      host.rbyte(d);
      chk("burst", bexp[i], d);
    end
    host.wbit(1'b1);
    host.stop();
    $display("test burst done");
    // Written data is taken and dropped; the stop clears the pointer.
    host.start();
    host.wbyte(8'hAA, a);
    host.wbyte(AIR_REG_Z_HI, a);
    host.wbyte(8'h5A, a);
    chk("data ack", 8'h00, {7'h0, a});
    host.stop();
    host.start();
    host.wbyte(8'hAB, a);
    host.rbyte(d);
    host.wbit(1'b1);
    host.stop();
    chk("ptr", 8'h00, d);
    // A foreign address gets no answer.
    host.start();
    host.wbyte(8'hA8, a);
    chk("nak", 8'h01, {7'h0, a});
    host.stop();
    // Trigger low: bus ignored, registers cleared; no byte is read meanwhile.
    @(posedge clk);
    en <= 1'b0;
    repeat (8) @(posedge lclk);
    host.start();
    host.wbyte(8'hAA, a);
    chk("off nak", 8'h01, {7'h0, a});
    host.stop();
    @(posedge clk);
    en <= 1'b1;
    repeat (8) @(posedge lclk);
    sel(AIR_REG_STATUS);
    host.rbyte(d);
    chk("status", 8'h00, d);
    host.wbit(1'b0);
    host.rbyte(d);
    chk("x hi", 8'h00, d);
    host.wbit(1'b1);
    host.stop();
    $display("test bus done");
    results();
  end
endmodule : air_i2c_regs_test
`default_nettype wire
